// >>> logic/nvsac_host.sv
// Host controller driving an nvSRAM through its strobes and store/busy pin
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Write strobe stays high during reads
// - Store/busy line high through every access
// - Command read cycles last read cycle time
// - Command sequence uses reads only
// - Six command reads consecutive, write high
// - Hardware store pulse at least 15 ns
// - Five fixed addresses then command address
module nvsac_host
  import nvsac_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8,
  parameter int STORE_WAIT = STORE_WAIT_CYCLES,
  parameter int RECALL_WAIT = RECALL_WAIT_CYCLES,
  parameter int SOFT_WAIT = SOFT_SEQ_CYCLES,
  parameter int POWERUP_WAIT = POWERUP_RECALL_CYCLES
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // User request
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Device pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_sel_n,
  output logic write_en_n,
  output logic out_en_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic hw_store_busy_n_in,
  output logic hw_store_busy_n_out,
  output logic hw_store_busy_n_oe
);
  nvsac_sync_if #(.DATA_W(DATA_W)) sync_bus ();
  nvsac_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [2:0] seq_step;
  logic [15:0] seq_cmd;
  logic [CNT_W-1:0] post_wait;

  nvsac_pin_sync #(.DATA_W(DATA_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .dq_in(dq_in),
    .hw_store_busy_n_in(hw_store_busy_n_in),
    .sync(sync_bus.src)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Main state machine driving strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= NVSAC_POWERUP;
      cnt <= '0;
      seq_step <= 3'h0;
      seq_cmd <= 16'h0000;
      post_wait <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      mem_addr <= '0;
      chip_sel_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      dq_out <= '0;
      dq_oe <= 1'b0;
      hw_store_busy_n_out <= 1'b0;
      hw_store_busy_n_oe <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      case (state)
        // Wait out power-up recall before any access
        NVSAC_POWERUP: begin
          if (cnt >= CNT_W'(POWERUP_WAIT - 1)) begin
            cnt <= '0;
            state <= NVSAC_IDLE;
            req_ready <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        NVSAC_IDLE: begin
          if (req_valid && sync_bus.hw_store_busy_n) begin
            req_ready <= 1'b0;
            cnt <= '0;
            mem_addr <= req_addr;
            case (req_op)
              OP_READ: begin
                chip_sel_n <= 1'b0;
                out_en_n <= 1'b0;
                write_en_n <= 1'b1;
                state <= NVSAC_READ;
              end
              OP_WRITE: begin
                chip_sel_n <= 1'b0;
                write_en_n <= 1'b0;
                out_en_n <= 1'b1;
                dq_out <= req_wdata;
                dq_oe <= 1'b1;
                state <= NVSAC_WRITE;
              end
              OP_HW_STORE: begin
                hw_store_busy_n_oe <= 1'b1;
                state <= NVSAC_STORE_LOW;
              end
              OP_SW_STORE, OP_SW_RECALL, OP_AS_DISABLE, OP_AS_ENABLE: begin
                seq_step <= 3'h0;
                seq_cmd <= (req_op == OP_SW_STORE) ? CMD_STORE :
                           (req_op == OP_SW_RECALL) ? CMD_RECALL :
                           (req_op == OP_AS_DISABLE) ? CMD_AS_DIS : CMD_AS_EN;
                post_wait <= CNT_W'(SOFT_WAIT) +
                  ((req_op == OP_SW_STORE) ? CNT_W'(STORE_WAIT) :
                   (req_op == OP_SW_RECALL) ? CNT_W'(RECALL_WAIT) : CNT_W'(0));
                state <= NVSAC_SEQ;
              end
              default: begin
                req_ready <= 1'b1;
                state <= NVSAC_IDLE;
              end
            endcase
          end
        end
        // Read held for full cycle time, data sampled at the end
        NVSAC_READ: begin
          if (cnt >= CNT_W'(READ_CYCLES + 1)) begin
            rsp_rdata <= sync_bus.dq;
            rsp_valid <= 1'b1;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            cnt <= '0;
            state <= NVSAC_GAP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        NVSAC_WRITE: begin
          if (cnt >= CNT_W'(WRITE_CYCLES - 1)) begin
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            cnt <= '0;
            state <= NVSAC_GAP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // One idle cycle; data held past end of write
        NVSAC_GAP: begin
          dq_oe <= 1'b0;
          req_ready <= 1'b1;
          state <= NVSAC_IDLE;
        end
        // Six consecutive chip-select controlled reads
        NVSAC_SEQ: begin
          write_en_n <= 1'b1;
          out_en_n <= 1'b1;
          if (cnt == '0) begin
            mem_addr <= ADDR_W'(nvsac_seq_addr(seq_step, seq_cmd));
            chip_sel_n <= 1'b0;
            cnt <= cnt + 1'b1;
          end else if (cnt >= CNT_W'(READ_CYCLES)) begin
            chip_sel_n <= 1'b1;
            cnt <= '0;
            if (seq_step == 3'h5) begin
              state <= NVSAC_WAIT;
            end else begin
              seq_step <= seq_step + 1'b1;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Device locked out; wait processing plus operation time
        NVSAC_WAIT: begin
          if (cnt >= post_wait) begin
            cnt <= '0;
            req_ready <= 1'b1;
            state <= NVSAC_IDLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Drive store line low for at least the pulse width
        NVSAC_STORE_LOW: begin
          if (cnt >= CNT_W'(HSTORE_PULSE_CYCLES)) begin
            hw_store_busy_n_oe <= 1'b0;
            cnt <= '0;
            state <= NVSAC_STORE_BUSY;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Device holds the line low while busy; skipped store releases it
        NVSAC_STORE_BUSY: begin
          if (cnt >= CNT_W'(2) && sync_bus.hw_store_busy_n) begin
            cnt <= '0;
            req_ready <= 1'b1;
            state <= NVSAC_IDLE;
          end else if (cnt < CNT_W'(2)) begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          state <= NVSAC_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule // nvsac_host
`default_nettype wire

// >>> logic/nvsac_pin_sync.sv
// Two-flop synchronisers for the data bus and store/busy pin
`timescale 1ns/1ps
`default_nettype none
module nvsac_pin_sync #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Raw pins
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic hw_store_busy_n_in,
  // Synchronised levels
  nvsac_sync_if.src sync
);
  logic [DATA_W-1:0] dq_meta;
  logic store_busy_meta;

  // Two stages; second stage feeds the sequencer only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dq_meta <= '0;
      store_busy_meta <= 1'b1;
      sync.dq <= '0;
      sync.hw_store_busy_n <= 1'b1;
    end else if (clk_en) begin
      dq_meta <= dq_in;
      store_busy_meta <= hw_store_busy_n_in;
      sync.dq <= dq_meta;
      sync.hw_store_busy_n <= store_busy_meta;
    end
  end
endmodule // nvsac_pin_sync
`default_nettype wire

// >>> logic/nvsac_pkg.sv
// Package: pin timing, command addresses and states for the nvSRAM host controller
`default_nettype none
package nvsac_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int READ_CYCLE_NS = 45;
  localparam int READ_CYCLES = (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_CYCLE_NS = 45;
  localparam int WRITE_CYCLES = (WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HSTORE_PULSE_NS = 15;
  localparam int HSTORE_PULSE_CYCLES = (HSTORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STORE_MS = 15;
  localparam int STORE_WAIT_CYCLES = STORE_MS * 1000 * 1000 / (CLK_PERIOD_PS / 1000) / 1000;
  localparam int RECALL_US = 100;
  localparam int RECALL_WAIT_CYCLES = RECALL_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int SOFT_SEQ_US = 70;
  localparam int SOFT_SEQ_CYCLES = SOFT_SEQ_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int POWERUP_RECALL_MS = 20;
  localparam int POWERUP_RECALL_CYCLES =
    POWERUP_RECALL_MS * 1000 * 1000 / (CLK_PERIOD_PS / 1000) / 1000;
  localparam int CNT_W = 24;
  // ----------------------------------------------------------------
  // Command addresses (low 16 bits)
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQ_A0 = 16'h4E38;
  localparam logic [15:0] SEQ_A1 = 16'hB1C7;
  localparam logic [15:0] SEQ_A2 = 16'h83E0;
  localparam logic [15:0] SEQ_A3 = 16'h7C1F;
  localparam logic [15:0] SEQ_A4 = 16'h703F;
  localparam logic [15:0] CMD_STORE = 16'h8FC0;
  localparam logic [15:0] CMD_RECALL = 16'h4C63;
  localparam logic [15:0] CMD_AS_DIS = 16'h8B45;
  localparam logic [15:0] CMD_AS_EN = 16'h8B46;
  // ----------------------------------------------------------------
  // Host operation codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_SW_STORE = 3'h2;
  localparam logic [2:0] OP_SW_RECALL = 3'h3;
  localparam logic [2:0] OP_AS_DISABLE = 3'h4;
  localparam logic [2:0] OP_AS_ENABLE = 3'h5;
  localparam logic [2:0] OP_HW_STORE = 3'h6;

  typedef enum logic [3:0] {
    NVSAC_POWERUP = 4'b0000,
    NVSAC_IDLE = 4'b0001,
    NVSAC_READ = 4'b0010,
    NVSAC_WRITE = 4'b0011,
    NVSAC_GAP = 4'b0100,
    NVSAC_SEQ = 4'b0101,
    NVSAC_WAIT = 4'b0110,
    NVSAC_STORE_LOW = 4'b0111,
    NVSAC_STORE_BUSY = 4'b1000
  } nvsac_state_t;

  // Address of step n of a software command ending in cmd
  function automatic logic [15:0] nvsac_seq_addr(input logic [2:0] n, input logic [15:0] cmd);
    case (n)
      3'h0: nvsac_seq_addr = SEQ_A0;
      3'h1: nvsac_seq_addr = SEQ_A1;
      3'h2: nvsac_seq_addr = SEQ_A2;
      3'h3: nvsac_seq_addr = SEQ_A3;
      3'h4: nvsac_seq_addr = SEQ_A4;
      default: nvsac_seq_addr = cmd;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> logic/nvsac_sync_if.sv
// Interface: synchronised pin levels from the input stage to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface nvsac_sync_if #(parameter int DATA_W = 8);
  logic [DATA_W-1:0] dq;
  logic hw_store_busy_n;
  modport src (output dq, output hw_store_busy_n);
  modport dst (input dq, input hw_store_busy_n);
endinterface
`default_nettype wire

// >>> sim/nvsac_dev_model.sv
// Model: clockless behavioural nvSRAM device timed by delays
`timescale 1ns/1ps
`default_nettype none
module nvsac_dev_model
  import nvsac_pkg::*;
#(parameter int TSS = 50, parameter int TGR = 10, parameter int TNV = 150) (
  // Strobes and address
  input wire logic [18:0] addr,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic hw_store_busy_n,
  // Data
  input wire logic [7:0] dq,
  output logic [7:0] dq_dev,
  output logic dq_dev_oe,
  // Status
  output logic busy,
  output logic [15:0] last_cmd,
  output logic [7:0] n_cmd,
  output logic [7:0] n_hw
);
  logic [7:0] mem [int];
  logic [15:0] seq [5] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
  logic dirty = 1'b0;
  logic early_w = 1'b0;
  int step = 0;
  // ----------------------------------------------------------------
  // Array access and nonvolatile operations
  // ----------------------------------------------------------------
  // Power-up recall holds the array locked
  initial begin
    {dq_dev, last_cmd, n_cmd, n_hw} = '0;
    busy = 1'b1;
    #100 busy = 1'b0;
  end
  // Early write floats the outputs
  always @(negedge cs_n) early_w = !we_n;
  assign dq_dev_oe = !cs_n && !oe_n && we_n && hw_store_busy_n && !busy && !early_w;
  // Read data, inverse of last value when released
  always @(dq_dev_oe, addr) dq_dev = !dq_dev_oe ? ~dq_dev : mem.exists(int'(addr)) ?
    mem[int'(addr)] : 8'h00;
  // Level write, ignored while locked
  always @(cs_n, we_n, dq, addr) if (!cs_n && !we_n && hw_store_busy_n && !busy) begin
    mem[int'(addr)] = dq;
    dirty = 1'b1;
  end
  // Processing time then lockout for store or recall
  task automatic nv_op();
    #TSS busy = 1'b1;
    #TNV busy = 1'b0;
    dirty = 1'b0;
  endtask
  // Command steps on select-controlled reads, low 16 bits
  always @(posedge cs_n) if (!busy) begin
    if (!we_n) step = 0;
    else if (step < 5 && addr[15:0] == seq[step]) step++;
    else if (step == 5 && addr[15:0] inside {CMD_STORE, CMD_RECALL, CMD_AS_DIS, CMD_AS_EN}) begin
      step = 0;
      last_cmd = addr[15:0];
      n_cmd = n_cmd + 8'h01;
      if (addr[15:0] inside {CMD_STORE, CMD_RECALL}) nv_op();
    end else step = int'(addr[15:0] == seq[0]);
  end
  // Grace delay, then store only after a write
  always @(negedge hw_store_busy_n) if (!busy && dirty) begin
    #TGR busy = 1'b1;
    n_hw = n_hw + 8'h01;
    #TNV busy = 1'b0;
    dirty = 1'b0;
  end
endmodule // nvsac_dev_model
`default_nettype wire

// >>> sim/nvsac_host_props.sv
// Checker: pin protocol properties of the nvSRAM host controller
`timescale 1ns/1ps
`default_nettype none
module nvsac_host_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Device pins and answer
  input wire logic [18:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic dq_oe,
  input wire logic rsp_valid,
  input wire logic hw_store_busy_n_out,
  input wire logic hw_store_busy_n_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Strobe and store line properties
  // ----------------------------------------------------------------
  a_read_we_high: assert property (!out_en_n |-> write_en_n)
    else $error("write strobe low while output enabled");
  a_store_idle_access: assert property (!chip_sel_n |-> !hw_store_busy_n_oe)
    else $error("store line pulled during access");
  a_cycle_min_len: assert property ($fell(chip_sel_n) |=> !chip_sel_n [*8])
    else $error("access shorter than nine cycles");
  a_read_no_drive: assert property ((!chip_sel_n && write_en_n) |-> !dq_oe)
    else $error("host drives data in a read");
  a_addr_held: assert property ((!chip_sel_n && !$past(chip_sel_n)) |-> $stable(mem_addr))
    else $error("address moved inside an access");
  a_pulse_width: assert property ($rose(hw_store_busy_n_oe) |=> hw_store_busy_n_oe [*3])
    else $error("store pulse shorter than four cycles");
  a_pulse_low: assert property (hw_store_busy_n_oe |-> !hw_store_busy_n_out)
    else $error("store line driven high");
  a_read_answer: assert property ($rose(out_en_n) |-> rsp_valid)
    else $error("read ended without answer");
endmodule // nvsac_host_props
bind nvsac_host nvsac_host_props u_props (.core_clk, .rst, .mem_addr, .chip_sel_n,
  .write_en_n, .out_en_n, .dq_oe, .rsp_valid, .hw_store_busy_n_out, .hw_store_busy_n_oe);
`default_nettype wire

// >>> sim/nvsac_host_test.sv
// Testbench: nvSRAM host controller against the behavioural device
`timescale 1ns/1ps
`default_nettype none
module nvsac_host_test;
  import nvsac_pkg::*;
  logic core_clk = 0, rst = 1, req_valid = 0, req_ready, rsp_valid, chip_sel_n, write_en_n;
  logic out_en_n, dq_oe, store_out, store_oe, dev_oe, busy;
  logic clk_en = 1'b1;
  logic [2:0] req_op = 0;
  logic [18:0] req_addr = 0, mem_addr;
  logic [7:0] req_wdata = 0, rsp_rdata, dq_out, dq_dev, got, n_cmd, n_hw;
  logic [15:0] last_cmd;
  int bad_count = 0, checks_done = 0;
  wire logic [7:0] dq_bus = dq_oe ? dq_out : dq_dev;
  wire logic hw_store_busy_n = (store_oe ? store_out : 1'b1) & !busy;
  nvsac_host #(.STORE_WAIT(20), .RECALL_WAIT(30), .SOFT_WAIT(40), .POWERUP_WAIT(50)) dut (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n), .out_en_n(out_en_n), .dq_in(dq_bus), .dq_out(dq_out),
    .dq_oe(dq_oe), .hw_store_busy_n_in(hw_store_busy_n), .hw_store_busy_n_out(store_out),
    .hw_store_busy_n_oe(store_oe));
  nvsac_dev_model u_dev (.addr(mem_addr), .cs_n(chip_sel_n), .we_n(write_en_n),
    .oe_n(out_en_n), .hw_store_busy_n(hw_store_busy_n), .dq(dq_bus), .dq_dev(dq_dev),
    .dq_dev_oe(dev_oe),
    .busy(busy), .last_cmd(last_cmd), .n_cmd(n_cmd), .n_hw(n_hw));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // One request, held until taken, then wait for ready
  task automatic op(input logic [2:0] code, input logic [18:0] a, input logic [7:0] d);
    int n;
    req_op <= code;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    n = 0;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
      if (rsp_valid === 1'b1) got = rsp_rdata;
      chk("bus contention", dq_oe & dev_oe, 1'b0);
    end while (req_ready !== 1'b1 && n < 400);
    chk("ready", req_ready, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rw();
    op(OP_WRITE, 19'h7_1234, 8'h5A);
    op(OP_WRITE, 19'h0_1234, 8'hA5);
    op(OP_READ, 19'h7_1234, 8'h00);
    chk("read data high", got, 8'h5A);
    op(OP_READ, 19'h0_1234, 8'h00);
    chk("read data low", got, 8'hA5);
  endtask
  task automatic t_cmds();
    logic [15:0] cmds [4] = '{CMD_STORE, CMD_RECALL, CMD_AS_DIS, CMD_AS_EN};
    for (int i = 0; i < 4; i++) begin
      op(OP_SW_STORE + 3'(i), 19'h0_0000, 8'h00);
      chk("command", last_cmd, cmds[i]);
      chk("command count", n_cmd, 8'(i + 1));
    end
  endtask
  task automatic t_hw();
    op(OP_HW_STORE, 19'h0_0000, 8'h00);
    chk("skipped store", n_hw, 8'h00);
    op(OP_WRITE, 19'h0_0042, 8'h3C);
    op(OP_HW_STORE, 19'h0_0000, 8'h00);
    chk("hardware store", n_hw, 8'h01);
    op(OP_READ, 19'h0_0042, 8'h00);
    chk("read after store", got, 8'h3C);
  endtask
  // Clock enable low holds a pending read off
  task automatic t_freeze();
    clk_en <= 1'b0;
    req_op <= OP_READ;
    req_addr <= 19'h7_1234;
    req_valid <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("frozen select", chip_sel_n, 1'b1);
    chk("frozen ready", req_ready, 1'b1);
    clk_en <= 1'b1;
    op(OP_READ, 19'h7_1234, 8'h00);
    chk("read after freeze", got, 8'h5A);
  endtask
  // Free-running clock
  initial forever #2.5 core_clk = ~core_clk;
  // Watchdog on a hung run
  initial begin
    #50us;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("ready in power-up", req_ready, 1'b0);
    t_rw();
    t_cmds();
    t_hw();
    t_freeze();
    end_sim();
  end
endmodule // nvsac_host_test
`default_nettype wire
